// File: src/mms_pkg.sv
// constants, types and serial map of the module management block
`default_nettype none
package mms_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned T_INIT_MS = 2000;
  localparam int unsigned T_RESET_MIN_US = 2;
  localparam int unsigned T_LP_US = 100;
  localparam int unsigned T_INT_ON_MS = 200;
  localparam int unsigned T_INT_OFF_US = 500;
  localparam int unsigned T_MASK_MS = 100;
  localparam int unsigned T_SEL_US = 100;
  localparam int unsigned T_PDN_ON_MS = 100;
  localparam int unsigned T_PDN_OFF_MS = 300;
  localparam int unsigned INIT_CYC = T_INIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned RESET_MIN_CYC = T_RESET_MIN_US * CLK_MHZ;
  localparam int unsigned RST_CW = $clog2(RESET_MIN_CYC + 1);
  // ==========================================================
  // pin synchroniser order {scl, sda, reset_n, select_n, lp_req}
  localparam logic [4:0] PIN_SYNC_RST = 5'h1e;
  localparam int unsigned PIN_SCL = 4;
  localparam int unsigned PIN_SDA = 3;
  localparam int unsigned PIN_RSTN = 2;
  localparam int unsigned PIN_SELN = 1;
  localparam int unsigned PIN_LPREQ = 0;
  // ==========================================================
  // two-wire serial map
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [7:0] ADR_STATUS = 8'h02;
  localparam logic [7:0] ADR_FLAG_LOS = 8'h03;
  localparam logic [7:0] ADR_FLAG_TXF = 8'h04;
  localparam logic [7:0] ADR_FLAG_AUX = 8'h05;
  localparam logic [7:0] ADR_PWR_CTRL = 8'h5d;
  localparam logic [7:0] ADR_MASK_LOS = 8'h64;
  localparam logic [7:0] ADR_MASK_TXF = 8'h65;
  localparam logic [7:0] ADR_MASK_AUX = 8'h66;
  localparam logic [7:0] ADR_PAGE = 8'h7f;
  localparam logic [7:0] PAGE_USER = 8'h02;
  localparam int unsigned UPPER_BIT = 7;
  localparam int unsigned PWR_OVR_BIT = 0;
  localparam int unsigned PWR_SET_BIT = 1;
  // ==========================================================
  // axi4-lite register map (byte addresses)
  localparam logic [11:0] AXI_STATUS = 12'h000;
  localparam logic [11:0] AXI_FLAGS = 12'h004;
  localparam logic [11:0] AXI_MASKS = 12'h008;
  localparam logic [11:0] AXI_AUX_COND = 12'h00c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] aux;
    logic [3:0] txf;
    logic [3:0] los;
  } mms_flags_t;
  typedef enum {
    TW_IDLE, TW_ADDR, TW_ACK_A, TW_WBYTE, TW_ACK_W, TW_RBYTE, TW_RACK
  } mms_tw_state_t;
endpackage
`default_nettype wire

// File: src/mms_user_mem.sv
// user storage page, registered read data
`timescale 1ns/10ps
`default_nettype none
module mms_user_mem #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  // ==========================================================
  // storage
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge aclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk)
  begin
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// File: src/mms_top.sv
// module management: init, flags, interrupt, power and serial port
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module mms_top #(
  parameter int unsigned INIT_CYCLES = mms_pkg::INIT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_in_n,
  input wire logic module_select_n,
  input wire logic low_power_request,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic interrupt_out_n,
  output logic low_power,
  output logic module_ready,
  input wire logic [3:0] rx_los,
  input wire logic [3:0] tx_fault
);
  localparam int unsigned IW = $clog2(INIT_CYCLES + 1);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // pin synchronisers
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise, scl_fall, start_evt, stop_evt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta_q <= mms_pkg::PIN_SYNC_RST;
      pin_sync_q <= mms_pkg::PIN_SYNC_RST;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      pin_meta_q <= {scl_in, sda_in, reset_in_n, module_select_n,
                     low_power_request};
      pin_sync_q <= pin_meta_q;
      scl_prev_q <= pin_sync_q[mms_pkg::PIN_SCL];
      sda_prev_q <= pin_sync_q[mms_pkg::PIN_SDA];
    end
  end

  wire logic scl_s = pin_sync_q[mms_pkg::PIN_SCL];
  wire logic sda_s = pin_sync_q[mms_pkg::PIN_SDA];
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_evt = scl_s && scl_prev_q && !sda_s && sda_prev_q;
  assign stop_evt = scl_s && scl_prev_q && sda_s && !sda_prev_q;

  // ==========================================================
  // reset pin filter and initialisation
  logic [mms_pkg::RST_CW-1:0] rst_cnt_q;
  logic hold_rst_q;
  logic [IW-1:0] init_cnt_q;
  logic init_done_q;

  // a glitch shorter than the minimum pulse is ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn || pin_sync_q[mms_pkg::PIN_RSTN])
    begin
      rst_cnt_q <= '0;
      hold_rst_q <= 1'b0;
    end
    else if (rst_cnt_q == mms_pkg::RST_CW'(mms_pkg::RESET_MIN_CYC))
    begin
      hold_rst_q <= 1'b1;
    end
    else
    begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || hold_rst_q)
    begin
      init_cnt_q <= '0;
      init_done_q <= 1'b0;
    end
    else if (!init_done_q)
    begin
      if (init_cnt_q == IW'(INIT_CYCLES - 1))
      begin
        init_done_q <= 1'b1;
      end
      else
      begin
        init_cnt_q <= init_cnt_q + 1'b1;
      end
    end
  end
  assign module_ready = init_done_q;

  // ==========================================================
  // serial port state machine
  mms_pkg::mms_tw_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q, first_q, nack_q, sda_oe_q;
  logic [7:0] rd_byte;
  logic tw_en, wr_en, ld_en;

  // deselect or not-ready drops any transfer at once
  assign tw_en = init_done_q && !pin_sync_q[mms_pkg::PIN_SELN];
  assign wr_en = scl_fall && state_q == mms_pkg::TW_WBYTE &&
                 bit_cnt_q == mms_pkg::BITS_PER_BYTE && !first_q;
  assign ld_en = scl_fall && !start_evt && !stop_evt &&
                 ((state_q == mms_pkg::TW_ACK_A && rw_q) ||
                  (state_q == mms_pkg::TW_RACK && !nack_q));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tw_en)
    begin
      state_q <= mms_pkg::TW_IDLE;
      bit_cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      if (!aresetn)
      begin
        ptr_q <= '0;
      end
    end
    else if (start_evt)
    begin
      state_q <= mms_pkg::TW_ADDR;
      bit_cnt_q <= '0;
    end
    else if (stop_evt)
    begin
      state_q <= mms_pkg::TW_IDLE;
    end
    else
    begin
      case (state_q)
        mms_pkg::TW_ADDR:
        begin
          if (scl_rise)
          begin
            rx_q <= {rx_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end
          else if (scl_fall && bit_cnt_q == mms_pkg::BITS_PER_BYTE)
          begin
            rw_q <= rx_q[0];
            state_q <= (rx_q[7:1] == mms_pkg::DEV_ADDR) ?
                       mms_pkg::TW_ACK_A : mms_pkg::TW_IDLE;
          end
        end
        mms_pkg::TW_ACK_A:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= '0;
            first_q <= 1'b1;
            tx_q <= rd_byte;
            state_q <= rw_q ? mms_pkg::TW_RBYTE : mms_pkg::TW_WBYTE;
          end
        end
        mms_pkg::TW_WBYTE:
        begin
          if (scl_rise)
          begin
            rx_q <= {rx_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end
          else if (scl_fall && bit_cnt_q == mms_pkg::BITS_PER_BYTE)
          begin
            state_q <= mms_pkg::TW_ACK_W;
            first_q <= 1'b0;
            ptr_q <= first_q ? rx_q : ptr_q + 8'h01;
          end
        end
        mms_pkg::TW_ACK_W:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= '0;
            state_q <= mms_pkg::TW_WBYTE;
          end
        end
        mms_pkg::TW_RBYTE:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_q == mms_pkg::LAST_TX_BIT)
            begin
              bit_cnt_q <= '0;
              ptr_q <= ptr_q + 8'h01;
              state_q <= mms_pkg::TW_RACK;
            end
            else
            begin
              tx_q <= {tx_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 1'b1;
            end
          end
        end
        mms_pkg::TW_RACK:
        begin
          if (scl_rise)
          begin
            nack_q <= sda_s;
          end
          else if (scl_fall)
          begin
            tx_q <= rd_byte;
            state_q <= nack_q ? mms_pkg::TW_IDLE : mms_pkg::TW_RBYTE;
          end
        end
        default:
        begin
          state_q <= mms_pkg::TW_IDLE;
        end
      endcase
    end
  end

  // open-drain: only ever pulls low
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tw_en)
    begin
      sda_oe_q <= 1'b0;
    end
    else
    begin
      sda_oe_q <= state_q == mms_pkg::TW_ACK_A ||
                  state_q == mms_pkg::TW_ACK_W ||
                  (state_q == mms_pkg::TW_RBYTE && !tx_q[7]);
    end
  end
  assign sda_oe = sda_oe_q;
  assign sda_out = 1'b0;

  // ==========================================================
  // control bytes: power and masks staged on write, live from stop; page live on write
  logic [7:0] page_q;
  logic [1:0] pwr_stage_q, pwr_q;
  mms_pkg::mms_flags_t mask_stage_q, mask_q;
  logic [7:0] mem_rdata;
  logic user_sel;

  assign user_sel = ptr_q[mms_pkg::UPPER_BIT] && page_q == mms_pkg::PAGE_USER;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || hold_rst_q)
    begin
      page_q <= '0;
      pwr_stage_q <= '0;
      mask_stage_q <= '0;
    end
    else if (wr_en)
    begin
      case (ptr_q)
        mms_pkg::ADR_PWR_CTRL: pwr_stage_q <= rx_q[1:0];
        mms_pkg::ADR_MASK_LOS: mask_stage_q.los <= rx_q[3:0];
        mms_pkg::ADR_MASK_TXF: mask_stage_q.txf <= rx_q[3:0];
        mms_pkg::ADR_MASK_AUX: mask_stage_q.aux <= rx_q;
        mms_pkg::ADR_PAGE: page_q <= rx_q;
        default: page_q <= page_q;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || hold_rst_q)
    begin
      pwr_q <= '0;
      mask_q <= '0;
    end
    else if (stop_evt && tw_en)
    begin
      pwr_q <= pwr_stage_q;
      mask_q <= mask_stage_q;
    end
  end

  mms_user_mem #(.AW(7), .DW(8)) u_user_mem (
    .aclk(aclk),
    .we(wr_en && user_sel),
    .waddr(ptr_q[6:0]),
    .wdata(rx_q),
    .raddr(ptr_q[6:0]),
    .rdata_q(mem_rdata)
  );

  // ==========================================================
  // flags, clear-on-read and interrupt
  mms_pkg::mms_flags_t flags_q, cond_prev_q, cond, rise, clr;
  logic ready_evt_q;
  logic [3:0] pend_q;
  logic [7:0] aux_cond_q;
  logic int_q;

  assign cond = '{aux: aux_cond_q, txf: tx_fault, los: rx_los};
  assign rise = init_done_q ? (cond & ~cond_prev_q) : '0;
  assign clr = (stop_evt && tw_en) ?
               mms_pkg::mms_flags_t'{aux: {8{pend_q[3]}},
                 txf: {4{pend_q[2]}},
                 los: {4{pend_q[1]}}} : '0;

  always_comb
  begin
    case (ptr_q)
      mms_pkg::ADR_STATUS: rd_byte = {7'h00, !init_done_q};
      mms_pkg::ADR_FLAG_LOS: rd_byte = {4'h0, flags_q.los};
      mms_pkg::ADR_FLAG_TXF: rd_byte = {4'h0, flags_q.txf};
      mms_pkg::ADR_FLAG_AUX: rd_byte = flags_q.aux;
      mms_pkg::ADR_PWR_CTRL: rd_byte = {6'h00, pwr_stage_q};
      mms_pkg::ADR_MASK_LOS: rd_byte = {4'h0, mask_stage_q.los};
      mms_pkg::ADR_MASK_TXF: rd_byte = {4'h0, mask_stage_q.txf};
      mms_pkg::ADR_MASK_AUX: rd_byte = mask_stage_q.aux;
      mms_pkg::ADR_PAGE: rd_byte = page_q;
      default: rd_byte = user_sel ? mem_rdata : 8'h00;
    endcase
  end

  // bytes read are only cleared once the transfer ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hold_rst_q || (stop_evt && tw_en))
    begin
      pend_q <= '0;
    end
    else if (ld_en)
    begin
      pend_q <= pend_q | {ptr_q == mms_pkg::ADR_FLAG_AUX,
                          ptr_q == mms_pkg::ADR_FLAG_TXF,
                          ptr_q == mms_pkg::ADR_FLAG_LOS,
                          ptr_q == mms_pkg::ADR_STATUS};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || hold_rst_q)
    begin
      flags_q <= '0;
      cond_prev_q <= '0;
      ready_evt_q <= 1'b0;
    end
    else
    begin
      cond_prev_q <= cond;
      // set beats clear; masks do not stop latching
      flags_q <= (flags_q & ~clr) | rise;
      // one-shot on the cycle init completes, so a read can clear it
      if (!init_done_q && init_cnt_q == IW'(INIT_CYCLES - 1))
      begin
        ready_evt_q <= 1'b1;
      end
      else if (stop_evt && tw_en && pend_q[0])
      begin
        ready_evt_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || hold_rst_q)
    begin
      int_q <= 1'b0;
    end
    else
    begin
      int_q <= ready_evt_q || |(flags_q & ~mask_q);
    end
  end
  assign interrupt_out_n = !int_q;

  // ==========================================================
  // power level
  logic low_power_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_power_q <= 1'b0;
    end
    else
    begin
      // override bit hands the choice to the power-set bit
      low_power_q <= pwr_q[mms_pkg::PWR_OVR_BIT] ?
                     pwr_q[mms_pkg::PWR_SET_BIT] :
                     pin_sync_q[mms_pkg::PIN_LPREQ];
    end
  end
  assign low_power = low_power_q;

  // ==========================================================
  // axi4-lite slave
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  function automatic logic axi_known(input logic [11:0] a);
    axi_known = a == mms_pkg::AXI_STATUS || a == mms_pkg::AXI_FLAGS ||
                a == mms_pkg::AXI_MASKS || a == mms_pkg::AXI_AUX_COND;
  endfunction

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= mms_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      aux_cond_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_have_q && w_have_q)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= axi_known(awaddr_q) ? mms_pkg::RESP_OKAY :
                   mms_pkg::RESP_SLVERR;
        if (awaddr_q == mms_pkg::AXI_AUX_COND && wstrb_q[0])
        begin
          aux_cond_q <= wdata_q[7:0];
        end
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= mms_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= axi_known(s_axi_araddr) ? mms_pkg::RESP_OKAY :
                 mms_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        mms_pkg::AXI_STATUS: rdata_q <= {26'h000_0000,
          page_q == mms_pkg::PAGE_USER, tw_en, int_q, low_power_q,
          hold_rst_q, init_done_q};
        mms_pkg::AXI_FLAGS: rdata_q <= {15'h0000, ready_evt_q, flags_q};
        mms_pkg::AXI_MASKS: rdata_q <= {16'h0000, mask_q};
        mms_pkg::AXI_AUX_COND: rdata_q <= {24'h00_0000, aux_cond_q};
        default: rdata_q <= '0;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // checks
  chk_lp_follow: assert property (
    !pwr_q[mms_pkg::PWR_OVR_BIT] && $rose(pin_sync_q[mms_pkg::PIN_LPREQ])
    |-> ##[1:2] low_power)
    else $error("low power not entered after request pin");
  chk_los_latch: assert property (
    init_done_q && !hold_rst_q && $rose(rx_los[0]) |=> flags_q.los[0])
    else $error("loss-of-signal flag not latched");
  chk_txf_int: assert property (
    init_done_q && !hold_rst_q && $rose(tx_fault[0]) && !mask_q.txf[0]
    |-> ##2 !interrupt_out_n)
    else $error("transmit fault did not raise interrupt");
  chk_mask_quiet: assert property (
    (!ready_evt_q && (flags_q & ~mask_q) == '0) [*2] |-> interrupt_out_n)
    else $error("interrupt asserted for masked flags only");
  chk_ready_int: assert property (
    $rose(ready_evt_q) |-> init_done_q ##1 !interrupt_out_n)
    else $error("ready event did not assert interrupt");
  chk_rst_hold: assert property (
    !pin_sync_q[mms_pkg::PIN_RSTN] [*8] ##1 hold_rst_q |=> !init_done_q)
    else $error("module functional while reset held");
  chk_deselect: assert property (
    pin_sync_q[mms_pkg::PIN_SELN] |=> !sda_oe && state_q == mms_pkg::TW_IDLE)
    else $error("serial port active while deselected");
  chk_clear_stop: assert property (
    $fell(flags_q.los[0]) |-> $past(stop_evt) || $past(hold_rst_q))
    else $error("flag cleared outside a stop");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule
`default_nettype wire

// File: verification/mms_host_model.sv
// two-wire host model for the serial port
`timescale 1ns/10ps
`default_nettype none
module mms_host_model (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  // ==========
  // scl stands high between frames, so no edges reach the block idle
  localparam realtime Q = 31.25;
  initial scl = 1'b1;
  initial pull = 1'b0;
  task automatic start();
    pull = 1'b0;
    #Q scl = 1'b1;
    #Q pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    pull = 1'b1;
    #Q scl = 1'b1;
    #Q pull = 1'b0;
    #Q;
  endtask
  // data moves only while scl is low
  task automatic io(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      pull = !v[i];
      #Q scl = 1'b1;
      #Q r[i] = sda;
      #Q scl = 1'b0;
      #Q;
    end
  endtask
endmodule
`default_nettype wire

// File: verification/mms_top_test.sv
// self-checking bench of the module management block
`timescale 1ns/10ps
`default_nettype none
module mms_top_test;
  // ==========
  // short init count keeps the run brief
  localparam int unsigned INIT = 200;
  localparam int unsigned W = 6;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdq;
  logic rst_n = 1'b1, sel_n = 1'b0, lp_req = 1'b0;
  logic [3:0] rx_los = 4'h0, tx_fault = 4'h0;
  logic scl, pull, sda_oe, sda_out, int_n, low_power, ready, ack_seen;
  logic [7:0] q;
  wire sda;
  int fails = 0;
  int checks_done = 0;
  // pull-up: released line reads high
  assign sda = !(pull || (sda_oe && !sda_out));
  always #4 aclk = !aclk;
  mms_top #(.INIT_CYCLES(INIT)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reset_in_n(rst_n),
    .module_select_n(sel_n), .low_power_request(lp_req), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .interrupt_out_n(int_n), .low_power(low_power), .module_ready(ready),
    .rx_los(rx_los), .tx_fault(tx_fault)
  );
  mms_host_model h (.scl(scl), .pull(pull), .sda(sda));
  // ==========
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("fails %0d checks_done %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bvalid !== 1'b1)
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rvalid !== 1'b1)
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    resp = rresp;
    rdq = rdata;
    rready <= 1'b0;
  endtask
  // one serial frame: pointer write, then a data byte or a read
  task automatic tw(input logic [7:0] p, input logic [7:0] d, input logic rd);
    logic [8:0] r;
    repeat (W) @(posedge aclk);
    h.start();
    h.io({mms_pkg::DEV_ADDR, 2'b01}, r);
    ack_seen = !r[0];
    h.io({p, 1'b1}, r);
    if (rd)
    begin
      h.start();
      h.io({mms_pkg::DEV_ADDR, 2'b11}, r);
      h.io(9'h1ff, r);
    end
    else
      h.io({d, 1'b1}, r);
    q = r[8:1];
    h.stop();
    repeat (W) @(posedge aclk);
  endtask
  task automatic fl(input logic [7:0] a, input logic [7:0] e);
    repeat (W) @(posedge aclk);
    check(int_n, 1'b0);
    tw(a, 8'h00, 1'b1);
    check(q, e);
    check(int_n, 1'b1);
  endtask
  // ==========
  task automatic t_init();
    check(ready, 1'b0);
    repeat (INIT + 4) @(posedge aclk);
    check(ready, 1'b1);
    check(int_n, 1'b0);
    fl(mms_pkg::ADR_STATUS, 8'h00);
    axr(mms_pkg::AXI_STATUS);
    check(rdq[0], 1'b1);
    axr(12'h010);
    check(resp, mms_pkg::RESP_SLVERR);
    axw(12'h010, 32'h0000_0001);
    check(resp, mms_pkg::RESP_SLVERR);
  endtask
  task automatic t_flags();
    rx_los <= 4'h1;
    fl(mms_pkg::ADR_FLAG_LOS, 8'h01);
    tx_fault <= 4'h5;
    fl(mms_pkg::ADR_FLAG_TXF, 8'h05);
    axw(mms_pkg::AXI_AUX_COND, 32'h0000_0080);
    check(resp, mms_pkg::RESP_OKAY);
    fl(mms_pkg::ADR_FLAG_AUX, 8'h80);
  endtask
  task automatic t_mask();
    tw(mms_pkg::ADR_MASK_LOS, 8'h02, 1'b0);
    rx_los <= 4'h3;
    repeat (W) @(posedge aclk);
    check(int_n, 1'b1);
    axr(mms_pkg::AXI_FLAGS);
    check(rdq, 32'h0000_0002);
    axr(mms_pkg::AXI_MASKS);
    check(rdq, 32'h0000_0002);
    tw(mms_pkg::ADR_MASK_LOS, 8'h00, 1'b0);
    fl(mms_pkg::ADR_FLAG_LOS, 8'h02);
  endtask
  task automatic t_power();
    lp_req <= 1'b1;
    repeat (W) @(posedge aclk);
    check(low_power, 1'b1);
    tw(mms_pkg::ADR_PWR_CTRL, 8'h01, 1'b0);
    check(low_power, 1'b0);
    lp_req <= 1'b0;
    tw(mms_pkg::ADR_PWR_CTRL, 8'h03, 1'b0);
    check(low_power, 1'b1);
    tw(mms_pkg::ADR_PWR_CTRL, 8'h00, 1'b0);
    check(low_power, 1'b0);
  endtask
  task automatic t_sel_page();
    sel_n <= 1'b1;
    tw(mms_pkg::ADR_STATUS, 8'h00, 1'b1);
    check(ack_seen, 1'b0);
    sel_n <= 1'b0;
    tw(mms_pkg::ADR_PAGE, mms_pkg::PAGE_USER, 1'b0);
    check(ack_seen, 1'b1);
    tw(8'h80, 8'h5a, 1'b0);
    tw(8'h80, 8'h00, 1'b1);
    check(q, 8'h5a);
  endtask
  task automatic t_pin_reset();
    rst_n <= 1'b0;
    repeat (100) @(posedge aclk);
    rst_n <= 1'b1;
    repeat (W) @(posedge aclk);
    check(ready, 1'b1);
    rst_n <= 1'b0;
    repeat (mms_pkg::RESET_MIN_CYC + 10) @(posedge aclk);
    check(ready, 1'b0);
    rst_n <= 1'b1;
    repeat (INIT + 10) @(posedge aclk);
    check(ready, 1'b1);
    check(int_n, 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_init();
    t_flags();
    t_mask();
    t_power();
    t_sel_page();
    t_pin_reset();
    conclude();
  end
  initial
  begin
    #500us;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
